// ==== sctl_regs.svh ====
// Register offsets, field widths, reset values and sizes for the sleep-gating block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef SCTL_REGS_SVH
`define SCTL_REGS_SVH

`define SCTL_NPER        28
`define SCTL_NSRC        3
`define SCTL_ADDR_W      5
`define SCTL_OFF_RAW     5'h00
`define SCTL_OFF_MASK    5'h04
`define SCTL_OFF_MSTAT   5'h08
`define SCTL_OFF_LEVEL   5'h0c
`define SCTL_OFF_GATE    5'h10
`define SCTL_OFF_RUN     5'h14
`define SCTL_OFF_SLEEP   5'h18
`define SCTL_OFF_DEEP    5'h1c
`define SCTL_BIT_MOSC    0
`define SCTL_BIT_PLL     1
`define SCTL_BIT_BOR     2
`define SCTL_LVL_MIN     4'h0
`define SCTL_LVL_DEF     4'h5
`define SCTL_LVL_MAX     4'ha
`define SCTL_MASK_RST    3'h0
`define SCTL_PER_RST     28'h0000000

`endif

// ==== sctl_pkg.sv ====
// Types shared by the sleep-gating block.
// Assumes sctl_regs.svh is on the include path.
`default_nettype none
`include "sctl_regs.svh"

package sctl_pkg;

    typedef logic [`SCTL_NPER-1:0] sctl_per_t;
    typedef logic [`SCTL_NSRC-1:0] sctl_src_t;

    // Wishbone request from the master.
    typedef struct packed {
        logic                    cyc;
        logic                    stb;
        logic                    we;
        logic [3:0]              sel;
        logic [`SCTL_ADDR_W-1:0] adr;
        logic [31:0]             dat;
    } sctl_wb_req_t;

    // Whole state of the block.
    typedef struct packed {
        sctl_src_t   sync1;
        sctl_src_t   sync2;
        sctl_src_t   sync3;
        sctl_src_t   raw;
        sctl_src_t   mask;
        logic [3:0]  level;
        logic        gate;
        sctl_per_t   run;
        sctl_per_t   slp;
        sctl_per_t   dsl;
        sctl_per_t   clk_en;
        logic        irq;
        logic        ack;
        logic [31:0] rdata;
    } sctl_state_t;

endpackage : sctl_pkg

`default_nettype wire

// ==== sctl_gate.sv ====
// Interrupt combining, regulator level and sleep clock gating for system control.
// Assumes a classic Wishbone master on clk_i and sleep indications from the core on clk_i.
//
// What this block does
// - A three-bit mask has one bit each for oscillator power-up, PLL lock and brown-out; a zero disables it.
// - Software may set any combination of the three mask bits independently.
// - A pending source reaches the interrupt line only while its mask bit is set.
// - Software can read the raw pending state and the masked pending state.
// - Status uses the same bit positions as the mask.
// - The regulator level holds eleven settings 2.25 V to 2.75 V in 50 mV steps, reset to 2.5 V.
// - A read returns the regulator level setting currently held.
// - With sleep gating off, its reset state, peripherals are clocked in sleep and deep-sleep as in run.
// - With gating on, run-enabled peripherals follow their own sleep and deep-sleep enables.
// - With gating on, a peripheral without deep-sleep enable is stopped while in deep-sleep.
// - On deep-sleep exit a run-enabled peripheral gets its clock back with its state kept.
// - With gating off, deep-sleep enables stay stored but have no effect.
// - With gating on, a deep-sleep-enabled peripheral keeps its clock in deep-sleep.
// - Software can clear selected pending sources until their condition occurs again.
// - Every peripheral is run-disabled after reset until software enables it.
`default_nettype none
`include "sctl_regs.svh"

module sctl_gate
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone slave
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [3:0]               sel_i,
    input  wire logic [`SCTL_ADDR_W-1:0]  adr_i,
    input  wire logic [31:0]              dat_i,
    output logic      [31:0]              dat_o,
    output logic                          ack_o,
    // Event sources, asynchronous
    input  wire logic                     main_osc_powerup_src_i,
    input  wire logic                     pll_locked_src_i,
    input  wire logic                     brownout_src_i,
    // Processor power state
    input  wire logic                     sleep_i,
    input  wire logic                     deep_sleep_i,
    // Outputs to the system
    output logic                          irq_o,
    output logic      [3:0]               regulator_level_sel_o,
    output logic      [`SCTL_NPER-1:0]    periph_clk_en_o,
    output logic      [`SCTL_NPER-1:0]    periph_run_en_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    // Address decode, used by both the read and the write path.
    function automatic logic hit(input logic [`SCTL_ADDR_W-1:0] a, input logic [`SCTL_ADDR_W-1:0] off);
        return a == off;
    endfunction

    sctl_pkg::sctl_state_t st;
    sctl_pkg::sctl_state_t next_st;
    sctl_pkg::sctl_wb_req_t req;
    sctl_pkg::sctl_src_t    evt;
    sctl_pkg::sctl_src_t    clr;
    sctl_pkg::sctl_per_t    want;
    logic                   wr;
    logic [31:0]            wv;
    logic [31:0]            rv;

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

    // Rising edges of the synchronised sources; the first stage is never looked at here.
    assign evt = st.sync2 & ~st.sync3;

    // A write takes effect only on the edge where ack is high.
    assign wr = req.cyc & req.stb & req.we & st.ack;

    // ----------------------------------------------------------------
    // Per-peripheral clock decision
    // ----------------------------------------------------------------

    generate
        for (genvar i = 0; i < `SCTL_NPER; i++)
        begin : g_per
            // Deep-sleep takes priority when the core reports both states at once.
            assign want[i] = (!st.gate || (!sleep_i && !deep_sleep_i)) ? st.run[i]
                           : deep_sleep_i ? (st.run[i] & st.dsl[i])
                           : (st.run[i] & st.slp[i]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    always_comb
    begin
        next_st = st;
        wv      = 32'h00000000;
        clr     = '0;
        next_st.sync1 = {brownout_src_i, pll_locked_src_i, main_osc_powerup_src_i};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;

        if (wr && hit(req.adr, `SCTL_OFF_RAW))
        begin
            wv  = merge(32'h00000000, req.dat, req.sel);
            clr = wv[`SCTL_NSRC-1:0];
        end
        // A new event in the clearing cycle survives the clear.
        next_st.raw = (st.raw & ~clr) | evt;

        if (wr && hit(req.adr, `SCTL_OFF_MASK))
        begin
            wv           = merge({29'h0, st.mask}, req.dat, req.sel);
            next_st.mask = wv[`SCTL_NSRC-1:0];
        end
        if (wr && hit(req.adr, `SCTL_OFF_LEVEL))
        begin
            wv = merge({28'h0, st.level}, req.dat, req.sel);
            // Codes above the top setting are ignored so the regulator never sees them.
            if (wv[3:0] <= `SCTL_LVL_MAX)
                next_st.level = wv[3:0];
        end
        if (wr && hit(req.adr, `SCTL_OFF_GATE))
        begin
            wv           = merge({31'h0, st.gate}, req.dat, req.sel);
            next_st.gate = wv[0];
        end
        if (wr && hit(req.adr, `SCTL_OFF_RUN))
        begin
            wv          = merge({4'h0, st.run}, req.dat, req.sel);
            next_st.run = wv[`SCTL_NPER-1:0];
        end
        if (wr && hit(req.adr, `SCTL_OFF_SLEEP))
        begin
            wv          = merge({4'h0, st.slp}, req.dat, req.sel);
            next_st.slp = wv[`SCTL_NPER-1:0];
        end
        if (wr && hit(req.adr, `SCTL_OFF_DEEP))
        begin
            wv          = merge({4'h0, st.dsl}, req.dat, req.sel);
            next_st.dsl = wv[`SCTL_NPER-1:0];
        end

        next_st.irq    = |(next_st.raw & next_st.mask);
        next_st.clk_en = want;

        // Read data is captured with ack so it stands for the whole answer cycle.
        rv = 32'h00000000;
        if (hit(req.adr, `SCTL_OFF_RAW))
            rv = {29'h0, st.raw};
        else if (hit(req.adr, `SCTL_OFF_MASK))
            rv = {29'h0, st.mask};
        else if (hit(req.adr, `SCTL_OFF_MSTAT))
            rv = {29'h0, st.raw & st.mask};
        else if (hit(req.adr, `SCTL_OFF_LEVEL))
            rv = {28'h0, st.level};
        else if (hit(req.adr, `SCTL_OFF_GATE))
            rv = {31'h0, st.gate};
        else if (hit(req.adr, `SCTL_OFF_RUN))
            rv = {4'h0, st.run};
        else if (hit(req.adr, `SCTL_OFF_SLEEP))
            rv = {4'h0, st.slp};
        else if (hit(req.adr, `SCTL_OFF_DEEP))
            rv = {4'h0, st.dsl};

        // One wait state: ack rises the cycle after the request is taken and drops a cycle later.
        next_st.ack = req.cyc & req.stb & ~st.ack;
        if (req.cyc && req.stb && !st.ack)
            next_st.rdata = req.we ? 32'h00000000 : rv;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // The synchronisers clear as well, so a source already high at release is seen as a rising edge.
            st       <= '0;
            st.mask  <= `SCTL_MASK_RST;
            st.level <= `SCTL_LVL_DEF;
            st.gate  <= 1'b0;
            st.run   <= `SCTL_PER_RST;
        end
        else
            st <= next_st;
    end

    assign dat_o                 = st.rdata;
    assign ack_o                 = st.ack;
    assign irq_o                 = st.irq;
    assign regulator_level_sel_o = st.level;
    assign periph_clk_en_o       = st.clk_en;
    assign periph_run_en_o       = st.run;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Each property samples registered state, so a consequent one cycle on sees the result of
    // the edge that its antecedent describes.

    // Reset values, seen at the first edge after release.
    a_mask_after_reset: assert property ($fell(rst_i) |-> st.mask == 3'h0 && st.run == '0)
        else $error("mask or run enables not cleared by reset");

    a_level_after_reset: assert property ($fell(rst_i) |-> regulator_level_sel_o == 4'h5)
        else $error("regulator level not at default after reset");

    a_level_in_range: assert property (regulator_level_sel_o <= 4'ha)
        else $error("regulator level outside eleven settings");

    // A code above the top setting is dropped rather than clipped.
    a_level_refused: assert property (wr && hit(req.adr, `SCTL_OFF_LEVEL) && sel_i[0] && dat_i[3:0] > 4'ha
                                      |=> $stable(regulator_level_sel_o))
        else $error("regulator level took a code above the top setting");

    a_level_read: assert property (cyc_i && stb_i && !we_i && !ack_o && hit(adr_i, `SCTL_OFF_LEVEL)
                                   |=> dat_o == {28'h0, $past(regulator_level_sel_o)})
        else $error("regulator level read back wrong");

    a_mask_write: assert property (wr && hit(req.adr, `SCTL_OFF_MASK) && sel_i[0]
                                   |=> st.mask == $past(dat_i[2:0]))
        else $error("mask bits not taken from the write");

    // An event meeting a mask write in one cycle follows the new mask, so that case is left out.
    a_masked_event_irq: assert property ((|(evt & st.mask)) && !(wr && hit(req.adr, `SCTL_OFF_MASK))
                                         |=> irq_o)
        else $error("enabled event did not raise the interrupt");

    a_disabled_no_irq: assert property (st.mask == 3'h0 |-> !irq_o)
        else $error("interrupt raised with every source disabled");

    // A new event wins over a clear of the same bit.
    a_set_beats_clear: assert property ((|(evt & clr)) |=> (st.raw & $past(evt & clr)) == $past(evt & clr))
        else $error("event lost in the clearing cycle");

    a_clear_drops_raw: assert property ((|(clr & ~evt)) |=> (st.raw & $past(clr & ~evt)) == 3'h0)
        else $error("pending source not cleared");

    a_raw_sticky: assert property (st.raw != 3'h0 && !(wr && hit(req.adr, `SCTL_OFF_RAW))
                                   |=> (st.raw & $past(st.raw)) == $past(st.raw))
        else $error("pending source dropped without a clear");

    a_raw_read: assert property (cyc_i && stb_i && !we_i && !ack_o && hit(adr_i, `SCTL_OFF_RAW)
                                 |=> dat_o == {29'h0, $past(st.raw)})
        else $error("raw status read wrong");

    a_mstat_read: assert property (cyc_i && stb_i && !we_i && !ack_o && adr_i == 5'h08
                                   |=> dat_o == {29'h0, $past(st.raw & st.mask)})
        else $error("masked status read wrong");

    // Clock enables are registered, so each follows its causes one cycle later.
    a_gate_off_run: assert property (!st.gate |=> periph_clk_en_o == $past(st.run))
        else $error("gating off but clocks differ from run enables");

    a_dsl_no_effect: assert property (!st.gate && deep_sleep_i |=> periph_clk_en_o == $past(st.run))
        else $error("deep-sleep enables acted with gating off");

    a_sleep_gate: assert property (st.gate && sleep_i && !deep_sleep_i
                                   |=> periph_clk_en_o == $past(st.run & st.slp))
        else $error("sleep clocks differ from sleep enables");

    a_deep_stop: assert property (st.gate && deep_sleep_i
                                  |=> (periph_clk_en_o & ~$past(st.dsl)) == '0)
        else $error("peripheral clocked in deep-sleep without enable");

    a_deep_keep: assert property (st.gate && deep_sleep_i
                                  |=> (periph_clk_en_o ^ $past(st.dsl & st.run)) == '0)
        else $error("deep-sleep enabled peripheral lost its clock");

    a_wake_restore: assert property (!sleep_i && !deep_sleep_i |=> periph_clk_en_o == $past(st.run))
        else $error("run clocks not restored after sleep");

    a_run_write: assert property (wr && hit(req.adr, `SCTL_OFF_RUN) && sel_i == 4'hf
                                  |=> periph_run_en_o == $past(dat_i[`SCTL_NPER-1:0]))
        else $error("run enables not taken from the write");

    a_dsl_write: assert property (wr && hit(req.adr, `SCTL_OFF_DEEP) && sel_i == 4'hf
                                  |=> st.dsl == $past(dat_i[`SCTL_NPER-1:0]))
        else $error("deep-sleep enables not stored");

    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

endmodule : sctl_gate

`default_nettype wire

// ==== sctl_sys_mdl.sv ====
// Model of the system around the gating block: event sources and core power state.
// Assumes the bench asks for events and power modes on clk_i.
`default_nettype none

module sctl_sys_mdl
#(
    parameter int HOLD = 4
)
(
    // Clock
    input  wire logic       clk_i,
    // Requests from the bench
    input  wire logic [2:0] fire_i,
    input  wire logic [1:0] mode_i,
    // Toward the block
    output logic      [2:0] src_o,
    output logic            sleep_o,
    output logic            deep_o
);
    int cnt = 0;

    initial src_o = 3'h0;

    // Sources drop again on their own, so a clear is never masked by a held level.
    always @(posedge clk_i)
    begin
        if (fire_i != 3'h0)
        begin
            src_o <= fire_i;
            cnt   <= HOLD;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
        else
            src_o <= 3'h0;
    end

    // Mode 1 is sleep, mode 2 is deep-sleep, anything else is run.
    assign sleep_o = (mode_i == 2'h1);
    assign deep_o  = (mode_i == 2'h2);
endmodule // sctl_sys_mdl

`default_nettype wire

// ==== sctl_gate_tb.sv ====
// Self-checking bench for the sleep-gating block.
// Assumes sctl_pkg, sctl_regs.svh and sctl_sys_mdl are compiled first.
`default_nettype none
`include "sctl_regs.svh"

module sctl_gate_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    sctl_pkg::sctl_wb_req_t req   = '0;
    logic [31:0]            dat_o;
    logic                   ack_o;
    logic                   irq_o;
    logic                   slp_i;
    logic                   dsl_i;
    logic [3:0]             lvl;
    logic [`SCTL_NPER-1:0]  clk_en;
    logic [`SCTL_NPER-1:0]  run_en;
    logic [2:0]             src;
    logic [2:0]             fire  = 3'h0;
    logic [1:0]             mode  = 2'h0;
    logic [31:0]            q[$];
    logic [31:0]            seed  = 32'hbfa2;
    logic [31:0]            run;
    logic [31:0]            slp;
    logic [31:0]            dsl;
    logic [31:0]            e;
    int                     err_total  = 0;
    int                     num_checks = 0;

    initial forever #5 clk_i = ~clk_i;

    sctl_gate dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc), .stb_i(req.stb), .we_i(req.we),
        .sel_i(req.sel), .adr_i(req.adr), .dat_i(req.dat), .dat_o(dat_o), .ack_o(ack_o),
        .main_osc_powerup_src_i(src[0]), .pll_locked_src_i(src[1]), .brownout_src_i(src[2]),
        .sleep_i(slp_i), .deep_sleep_i(dsl_i), .irq_o(irq_o), .regulator_level_sel_o(lvl),
        .periph_clk_en_o(clk_en), .periph_run_en_o(run_en));

    sctl_sys_mdl sys (.clk_i(clk_i), .fire_i(fire), .mode_i(mode), .src_o(src), .sleep_o(slp_i),
        .deep_o(dsl_i));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // The request is held until ack is seen, then released for at least one cycle.
    // Only the watchdog ends a wait for ack.
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        req <= '0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] x);
        q.push_back(x);
        wb(1'b0, a, 32'h0);
    endtask

    // Read results are compared in the order the reads were issued.
    always @(posedge clk_i)
        if (ack_o === 1'b1 && req.we === 1'b0 && q.size() > 0)
            chk(dat_o, q.pop_front());

    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({28'h0, lvl}, 32'h5);
        chk({4'h0, run_en}, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        rd(`SCTL_OFF_MASK, 32'h0);
        rd(`SCTL_OFF_GATE, 32'h0);
        rd(`SCTL_OFF_LEVEL, 32'h5);
        wb(1'b1, `SCTL_OFF_LEVEL, 32'ha);
        rd(`SCTL_OFF_LEVEL, 32'ha);
        wb(1'b1, `SCTL_OFF_LEVEL, 32'hb);
        rd(`SCTL_OFF_LEVEL, 32'ha);
        chk({28'h0, lvl}, 32'ha);
        fire <= 3'h7;
        @(posedge clk_i);
        fire <= 3'h0;
        repeat (10) @(posedge clk_i);
        rd(`SCTL_OFF_RAW, 32'h7);
        chk({31'h0, irq_o}, 32'h0);
        for (int m = 0; m < 8; m++)
        begin
            wb(1'b1, `SCTL_OFF_MASK, 32'(m));
            rd(`SCTL_OFF_MSTAT, 32'(m));
            chk({31'h0, irq_o}, {31'h0, m != 0});
        end
        wb(1'b1, `SCTL_OFF_RAW, 32'h2);
        rd(`SCTL_OFF_RAW, 32'h5);
        wb(1'b1, `SCTL_OFF_MASK, 32'h2);
        rd(`SCTL_OFF_MSTAT, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        fire <= 3'h2;
        @(posedge clk_i);
        fire <= 3'h0;
        repeat (10) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        rd(`SCTL_OFF_MSTAT, 32'h2);
        wb(1'b1, `SCTL_OFF_RAW, 32'h7);
        rd(`SCTL_OFF_RAW, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        seed = xs(seed);
        run = seed & 32'h0fffffff;
        seed = xs(seed);
        slp = seed & 32'h0fffffff;
        seed = xs(seed);
        dsl = seed & 32'h0fffffff;
        wb(1'b1, `SCTL_OFF_RUN, run);
        wb(1'b1, `SCTL_OFF_SLEEP, slp);
        wb(1'b1, `SCTL_OFF_DEEP, dsl);
        rd(`SCTL_OFF_DEEP, dsl);
        chk({4'h0, run_en}, run);
        for (int g = 0; g < 2; g++)
        begin
            wb(1'b1, `SCTL_OFF_GATE, 32'(g));
            for (int m = 0; m < 3; m++)
            begin
                mode <= 2'(m);
                repeat (3) @(posedge clk_i);
                e = (g == 1 && m == 2) ? (run & dsl) : (g == 1 && m == 1) ? (run & slp) : run;
                chk({4'h0, clk_en}, e);
            end
        end
        mode <= 2'h0;
        repeat (3) @(posedge clk_i);
        chk({4'h0, clk_en}, run);
        repeat (4) @(posedge clk_i);
        tally_and_finish();
    end
endmodule // sctl_gate_tb

`default_nettype wire
